// >>> hdl/uasy_pkg.sv
// Purpose: Shared constants and types of the asynchronous serial channel.
// Assumes: APB word addressing, byte address is four times the register index.
// Notes:   Register indices keep the printed offsets.
package uasy_pkg;
   localparam int          PADDR_W       = 18;
   // Register indices
   localparam logic [15:0] IDX_ASYNC     = 16'hff70;
   localparam logic [15:0] IDX_ERR       = 16'hff71;
   localparam logic [15:0] IDX_SOP       = 16'hff72;
   localparam logic [15:0] IDX_BAUD      = 16'hff73;
   localparam logic [15:0] IDX_DATA      = 16'hff74;
   localparam logic [15:0] IDX_TXFLAG    = 16'hff75;
   // Reset values
   localparam logic [7:0]  ASYNC_RST     = 8'h00;
   localparam logic [7:0]  SOP_RST       = 8'h00;
   localparam logic [7:0]  BAUD_RST      = 8'h00;
   localparam logic        TXD_IDLE      = 1'b1;
   // Writable bits
   localparam logic [7:0]  ASYNC_WMASK   = 8'hfc;
   localparam logic [7:0]  SOP_WMASK     = 8'hcf;
   localparam logic [7:0]  BAUD_WMASK    = 8'hf0;
   // async_mode_control fields
   localparam int          ASM_TXE       = 7;
   localparam int          ASM_RXE       = 6;
   localparam int          ASM_PAR_LO    = 4;
   localparam int          ASM_CL        = 3;
   localparam int          ASM_SL        = 2;
   // serial_op_mode_control fields
   localparam int          SOM_EN        = 7;
   localparam int          SOM_SSE       = 6;
   localparam int          SOM_DAP       = 3;
   localparam int          SOM_DIR       = 2;
   localparam int          SOM_CCK       = 1;
   localparam int          SOM_CKP       = 0;
   // baud_rate_control field
   localparam int          BRC_SEL_LO    = 4;
   // Receive error bits
   localparam int          ERR_PE        = 2;
   localparam int          ERR_FE        = 1;
   localparam int          ERR_OV        = 0;
   // Timing in baud ticks, eight to a bit
   localparam logic [2:0]  HALF_BIT      = 3'h3;
   localparam logic [2:0]  BIT_LAST      = 3'h7;
   typedef enum logic [1:0] {
      PAR_NONE = 2'b00,
      PAR_ZERO = 2'b01,
      PAR_ODD  = 2'b10,
      PAR_EVEN = 2'b11
   } uasy_par_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} uasy_rx_t;
endpackage : uasy_pkg

// >>> hdl/uasy_baud.sv
// Purpose: Baud tick generator, eight ticks to a bit.
// Assumes: sel 0..7 gives a tick every 2^(sel+2) clocks.
// Notes:   Codes 8 and up give no tick; the external baud pin is not built.
module uasy_baud import uasy_pkg::*; (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Control
   input  wire logic       run,
   input  wire logic [3:0] sel,
   output logic            tick
);
   typedef struct packed {
      logic [8:0] cnt;
      logic       tick;
   } uasy_baud_st_t;
   uasy_baud_st_t s, n;
   logic [9:0]    span;
   logic [8:0]    limit;
   always_comb begin
      n     = s;
      span  = 10'h004 << sel[2:0];
      limit = span[8:0] - 9'h001;
      n.tick = 1'b0;
      if (!run || sel[3]) begin
         n.cnt = 9'h000;
      end else if (s.cnt >= limit) begin
         n.cnt  = 9'h000;
         n.tick = 1'b1;
      end else begin
         n.cnt = s.cnt + 9'h001;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) s <= '0;
      else          s <= n;
   end
   assign tick = s.tick;
endmodule : uasy_baud

// >>> hdl/uasy_tx.sv
// Purpose: Transmit framer and shifter.
// Assumes: One baud tick is an eighth of a bit.
// Notes:   A load while busy or disabled is dropped.
module uasy_tx import uasy_pkg::*; (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Control
   input  wire logic       tick,
   input  wire logic       load,
   input  wire logic [7:0] data,
   input  wire logic       enable,
   input  wire logic [1:0] par_mode,
   input  wire logic       char8,
   input  wire logic       stop2,
   // Status and line
   output logic            txd,
   output logic            busy,
   output logic            done
);
   typedef struct packed {
      logic        busy;
      logic        done;
      logic        txd;
      logic [11:0] frame;
      logic [3:0]  left;
      logic [2:0]  ph;
   } uasy_tx_st_t;
   uasy_tx_st_t s, n;
   logic [7:0]  d;
   logic [3:0]  ppos;
   logic        pbit;
   logic        haspar;
   logic [11:0] fr;
   logic [11:0] pmask;
   always_comb begin
      n      = s;
      n.done = 1'b0;
      d      = char8 ? data : {1'b0, data[6:0]};
      ppos   = char8 ? 4'd9 : 4'd8;
      pmask  = char8 ? 12'h3fe : 12'h1fe;
      haspar = (par_mode != PAR_NONE);
      case (par_mode)
         PAR_EVEN: pbit = ^d;
         PAR_ODD:  pbit = ~(^d);
         default:  pbit = 1'b0;
      endcase
      fr      = 12'hfff;
      fr[0]   = 1'b0;
      fr[8:1] = d;
      if (!char8) fr[8] = 1'b1;
      if (haspar) fr[ppos] = pbit;
      if (!enable) begin
         n.busy = 1'b0;
         n.txd  = TXD_IDLE;
      end else if (!s.busy) begin
         if (load) begin
            n.frame = fr;
            n.left  = (char8 ? 4'd10 : 4'd9) + {3'b000, haspar} + {3'b000, stop2};
            n.busy  = 1'b1;
            n.txd   = 1'b0;
            n.ph    = 3'h0;
         end
      end else if (tick) begin
         n.ph = s.ph + 3'h1;
         if (s.ph == BIT_LAST) begin
            n.frame = {1'b1, s.frame[11:1]};
            n.left  = s.left - 4'h1;
            n.txd   = s.frame[1];
            if (s.left == 4'h1) begin
               n.busy = 1'b0;
               n.done = 1'b1;
               n.txd  = TXD_IDLE;
            end
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) s <= '{txd: TXD_IDLE, default: '0};
      else          s <= n;
   end
   assign txd  = s.txd;
   assign busy = s.busy;
   assign done = s.done;

   a_tx_even_par: assert property (@(posedge pclk) disable iff (!presetn)
      load && enable && !s.busy && par_mode == PAR_EVEN |=> !(^(s.frame & pmask)))
      else $error("even parity frame has odd count");
   a_tx_odd_par: assert property (@(posedge pclk) disable iff (!presetn)
      load && enable && !s.busy && par_mode == PAR_ODD |=> ^(s.frame & pmask))
      else $error("odd parity frame has even count");
   a_tx_zero_par: assert property (@(posedge pclk) disable iff (!presetn)
      load && enable && !s.busy && par_mode == PAR_ZERO |=> s.frame[ppos] == 1'b0)
      else $error("zero parity bit not zero");
   a_tx_idle_mark: assert property (@(posedge pclk) disable iff (!presetn)
      !s.busy |-> s.txd)
      else $error("line not high while idle");
   a_tx_done_end: assert property (@(posedge pclk) disable iff (!presetn)
      s.done |-> !s.busy && $past(s.busy) && s.left == 4'h0)
      else $error("done without end of frame");
endmodule : uasy_tx

// >>> hdl/uasy_top.sv
// Purpose: Asynchronous serial channel with APB registers.
// Assumes: serial_rx_pin and slave_select_pin are asynchronous to pclk.
// Notes:   Three-wire shifting is not built; its mode bits are stored and all but DAP and DIR drive pins.
//
// The APB interface to the registers was decided locally.
module uasy_top import uasy_pkg::*; (
   // Clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // APB slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [PADDR_W-1:0] paddr,
   input  wire logic [31:0]        pwdata,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr,
   // Serial line
   input  wire logic               serial_rx_pin,
   output logic                    serial_tx_pin,
   // Completion events
   output logic                    transmit_done_irq,
   output logic                    receive_done_irq,
   // Three-wire mode pins
   input  wire logic               slave_select_pin,
   output logic                    comm_allowed,
   output logic                    sync_serial_clock_pin_o,
   output logic                    sync_serial_clock_pin_oe
);
   typedef struct packed {
      logic [7:0]  amode;
      logic [7:0]  som;
      logic [7:0]  brate;
      logic [7:0]  rxbuf;
      logic [2:0]  err;
      logic        unread;
      logic        txflag;
      logic        rx_irq;
      uasy_rx_t    rx_st;
      logic [2:0]  rx_cnt;
      logic [3:0]  rx_bits;
      logic [8:0]  rx_sh;
      logic        rx_s1;
      logic        rx_s2;
      logic        ss_s1;
      logic        ss_s2;
      logic        comm_ok;
      logic        sck_o;
      logic        sck_oe;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } uasy_top_st_t;

   uasy_top_st_t s, n;
   logic         tick;
   logic         tx_done;
   logic         tx_busy;
   logic         tx_load;
   logic         rd_buf;
   logic         finish;
   logic         setup;
   logic         access;
   logic         mapped;
   logic [15:0]  idx;
   logic [1:0]   pmode;
   logic         haspar;
   logic [3:0]   k;
   logic [8:0]   aligned;
   logic [7:0]   dat;
   logic         ones;
   logic         pe;

   uasy_baud u_baud (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (s.amode[ASM_TXE] | s.amode[ASM_RXE]),
      .sel     (s.brate[BRC_SEL_LO +: 4]),
      .tick    (tick)
   );

   uasy_tx u_tx (
      .pclk     (pclk),
      .presetn  (presetn),
      .tick     (tick),
      .load     (tx_load),
      .data     (pwdata[7:0]),
      .enable   (s.amode[ASM_TXE]),
      .par_mode (pmode),
      .char8    (s.amode[ASM_CL]),
      .stop2    (s.amode[ASM_SL]),
      .txd      (serial_tx_pin),
      .busy     (tx_busy),
      .done     (tx_done)
   );

   always_comb begin
      n         = s;
      tx_load   = 1'b0;
      rd_buf    = 1'b0;
      finish    = 1'b0;
      n.rx_s1   = serial_rx_pin;
      n.rx_s2   = s.rx_s1;
      n.ss_s1   = slave_select_pin;
      n.ss_s2   = s.ss_s1;
      n.rx_irq  = 1'b0;
      n.pready  = 1'b0;
      n.pslverr = 1'b0;
      idx       = paddr[PADDR_W-1:2];
      pmode     = s.amode[ASM_PAR_LO +: 2];
      haspar    = (pmode != PAR_NONE);
      setup     = psel & ~penable;
      access    = psel & penable & s.pready;
      mapped    = (paddr[1:0] == 2'b00) && (idx inside {IDX_ASYNC, IDX_ERR, IDX_SOP,
                                                        IDX_BAUD, IDX_DATA, IDX_TXFLAG});
      // Answer is prepared in setup so the access phase sees a registered word
      if (setup) begin
         n.pready  = 1'b1;
         n.pslverr = ~mapped;
         n.prdata  = 32'h0000_0000;
         if (!pwrite && mapped) begin
            case (idx)
               IDX_ASYNC: n.prdata = {24'h00_0000, s.amode};
               IDX_ERR:   n.prdata = {29'h0000_0000, s.err};
               IDX_SOP:   n.prdata = {24'h00_0000, s.som};
               IDX_BAUD:  n.prdata = {24'h00_0000, s.brate};
               IDX_DATA:  n.prdata = {24'h00_0000, s.rxbuf};
               default:   n.prdata = {30'h0000_0000, tx_busy, s.txflag};
            endcase
         end
      end
      if (access && pwrite && mapped) begin
         case (idx)
            IDX_ASYNC:  n.amode = pwdata[7:0] & ASYNC_WMASK;
            IDX_SOP:    n.som   = pwdata[7:0] & SOP_WMASK;
            IDX_BAUD:   n.brate = pwdata[7:0] & BAUD_WMASK;
            IDX_DATA:   tx_load = s.amode[ASM_TXE];
            IDX_TXFLAG: begin
               if (pwdata[0]) n.txflag = 1'b0;
            end
            default:    n.amode = s.amode;
         endcase
      end
      // A frame that landed during setup makes the read stale; keep it unread
      if (access && !pwrite && mapped && idx == IDX_DATA && !s.rx_irq) begin
         rd_buf   = 1'b1;
         n.err    = 3'b000;
         n.unread = 1'b0;
      end
      if (tx_done) n.txflag = 1'b1;

      // Receive framing
      k       = (s.amode[ASM_CL] ? 4'd8 : 4'd7) + {3'b000, haspar};
      aligned = s.rx_sh >> (4'd9 - k);
      dat     = s.amode[ASM_CL] ? aligned[7:0] : {1'b0, aligned[6:0]};
      ones    = ^aligned;
      case (pmode)
         PAR_EVEN: pe = ones;
         PAR_ODD:  pe = ~ones;
         default:  pe = 1'b0;
      endcase
      if (!s.amode[ASM_RXE]) begin
         n.rx_st = RX_IDLE;
      end else begin
         unique case (s.rx_st)
            RX_IDLE: begin
               if (!s.rx_s2) begin
                  n.rx_st  = RX_START;
                  n.rx_cnt = 3'h0;
               end
            end
            RX_START: begin
               if (tick) begin
                  n.rx_cnt = s.rx_cnt + 3'h1;
                  if (s.rx_cnt == HALF_BIT) begin
                     if (!s.rx_s2) begin
                        n.rx_st   = RX_BITS;
                        n.rx_cnt  = 3'h0;
                        n.rx_bits = 4'h0;
                     end else begin
                        n.rx_st = RX_IDLE;
                     end
                  end
               end
            end
            RX_BITS: begin
               if (tick) begin
                  n.rx_cnt = s.rx_cnt + 3'h1;
                  if (s.rx_cnt == BIT_LAST) begin
                     n.rx_bits = s.rx_bits + 4'h1;
                     if (s.rx_bits == k) finish = 1'b1;
                     else n.rx_sh = {s.rx_s2, s.rx_sh[8:1]};
                  end
               end
            end
         endcase
      end
      // A frame end wins over a buffer read in the same cycle
      if (finish) begin
         n.rx_st          = RX_IDLE;
         n.rxbuf          = dat;
         n.err[ERR_PE]    = pe;
         n.err[ERR_FE]    = ~s.rx_s2;
         n.err[ERR_OV]    = s.unread & ~rd_buf;
         n.unread         = 1'b1;
         n.rx_irq         = 1'b1;
      end

      n.comm_ok = ~s.som[SOM_SSE] | ~s.ss_s2;
      n.sck_oe  = s.som[SOM_EN] & s.som[SOM_CCK];
      n.sck_o   = ~s.som[SOM_CKP];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s       <= '0;
         s.amode <= ASYNC_RST;
         s.som   <= SOP_RST;
         s.brate <= BAUD_RST;
      end else begin
         s <= n;
      end
   end

   assign prdata                   = s.prdata;
   assign pready                   = s.pready;
   assign pslverr                  = s.pslverr;
   assign transmit_done_irq        = tx_done;
   assign receive_done_irq         = s.rx_irq;
   assign comm_allowed             = s.comm_ok;
   assign sync_serial_clock_pin_o  = s.sck_o;
   assign sync_serial_clock_pin_oe = s.sck_oe;

   a_start_half_bit: assert property (@(posedge pclk) disable iff (!presetn)
      s.rx_st == RX_BITS && $past(s.rx_st) == RX_START |-> !$past(s.rx_s2) && $past(s.rx_cnt) == HALF_BIT)
      else $error("start accepted without low half-bit sample");
   a_irq_has_data: assert property (@(posedge pclk) disable iff (!presetn)
      s.rx_irq |-> s.unread && $past(s.rx_st) == RX_BITS)
      else $error("receive interrupt without buffered frame");
   a_rx_disable_stop: assert property (@(posedge pclk) disable iff (!presetn)
      !s.amode[ASM_RXE] |=> s.rx_st == RX_IDLE && !s.rx_irq && $stable(s.rxbuf))
      else $error("reception continued after disable");
   a_overrun_set: assert property (@(posedge pclk) disable iff (!presetn)
      s.rx_irq && $past(s.unread) && !$past(rd_buf) |-> s.err[ERR_OV])
      else $error("overrun not flagged");
   a_read_clears: assert property (@(posedge pclk) disable iff (!presetn)
      rd_buf |=> s.err == 3'b000 || s.rx_irq)
      else $error("status not cleared by buffer read");
   a_no_par_err: assert property (@(posedge pclk) disable iff (!presetn)
      s.rx_irq && !s.amode[ASM_PAR_LO + 1] |-> !s.err[ERR_PE])
      else $error("parity error without checked parity");
   a_char7_top: assert property (@(posedge pclk) disable iff (!presetn)
      s.rx_irq && !s.amode[ASM_CL] |-> s.rxbuf[7] == 1'b0)
      else $error("bit 7 not zero for 7-bit character");
   a_som_reserved: assert property (@(posedge pclk) disable iff (!presetn)
      s.som[5:4] == 2'b00)
      else $error("reserved mode bits set");
   c_rx_frame:   cover property (@(posedge pclk) disable iff (!presetn) s.rx_irq);
   c_tx_frame:   cover property (@(posedge pclk) disable iff (!presetn) tx_done);
   c_frame_err:  cover property (@(posedge pclk) disable iff (!presetn) s.rx_irq && s.err[ERR_FE]);
   c_overrun:    cover property (@(posedge pclk) disable iff (!presetn) s.rx_irq && s.err[ERR_OV]);
endmodule : uasy_top

// >>> bench/uasy_remote.sv
// Purpose: Remote asynchronous serial device facing the channel.
// Assumes: 32 clocks to a bit, line idles high.
// Notes:   A low stop bit goes back high after 24 clocks, which keeps mid-bit sampling but
//          leaves only a short low tail that the receiver must reject as a false start.
module uasy_remote (
   // Clock
   input  wire logic        pclk,
   // Line
   input  wire logic        serial_tx_pin,
   output logic             serial_rx_pin,
   // Decode setup and result
   input  wire logic [3:0]  frame_bits,
   output logic [11:0]      got
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int BIT_CLKS = 32;

   initial begin
      serial_rx_pin = 1'b1;
      got = 12'h000;
   end

   task automatic send(input logic [7:0] d, input int nb, input bit has_p, input logic p, input logic stp);
      logic [10:0] f;
      int          n;
      int          i;
      f = 11'h000;
      for (i = 0; i < nb; i++) begin
         f[i+1] = d[i];
      end
      n = nb + 1;
      if (has_p) begin
         f[n] = p;
         n++;
      end
      f[n] = stp;
      n++;
      for (i = 0; i < n; i++) begin
         serial_rx_pin <= f[i];
         repeat (BIT_CLKS - 8) @(posedge pclk);
         if (i == n - 1) begin
            serial_rx_pin <= 1'b1;
         end
         repeat (8) @(posedge pclk);
      end
   endtask : send

   // Mid-bit decode of what the channel sends
   always begin : decode
      int i;
      @(posedge pclk);
      if (serial_tx_pin === 1'b0) begin
         repeat (BIT_CLKS / 2) @(posedge pclk);
         for (i = 1; i <= frame_bits; i++) begin
            repeat (BIT_CLKS) @(posedge pclk);
            got[i-1] <= serial_tx_pin;
         end
      end
   end
endmodule : uasy_remote

// >>> bench/tb.sv
// Purpose: Self-checking bench for the asynchronous serial channel.
// Assumes: Baud select stays 0, so 32 clocks to a bit.
// Notes:   Sent frames are judged through the remote model's decode.
module tb import uasy_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic               serial_rx_pin, serial_tx_pin, transmit_done_irq, receive_done_irq;
   logic               slave_select_pin, comm_allowed, sync_serial_clock_pin_o, sync_serial_clock_pin_oe;
   logic [PADDR_W-1:0] paddr;
   logic [31:0]        pwdata, prdata, rd;
   logic [3:0]         frame_bits;
   logic [11:0]        got;
   int                 bad_count, n_compared, tx_irqs, rx_irqs;
   // {parity, char8, stop2, data}
   localparam logic [11:0] TXT [0:5] = '{12'h2a7, 12'h7a7, 12'haa7, 12'hea7, 12'he33, 12'h881};
   // {parity, char8, flip parity, stop, read buffer, error bits, data}
   localparam logic [16:0] RXT [0:7] = '{17'h1d85a, 17'h1f45a, 17'h1d93c, 17'h17ca5,
                                         17'h0f896, 17'h058c3, 17'h04a0f, 17'h018ff};

   uasy_top u_uasy_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .serial_rx_pin, .serial_tx_pin, .transmit_done_irq, .receive_done_irq, .slave_select_pin,
      .comm_allowed, .sync_serial_clock_pin_o, .sync_serial_clock_pin_oe);
   uasy_remote u_uasy_remote (.pclk, .serial_tx_pin, .serial_rx_pin, .frame_bits, .got);

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      if (transmit_done_irq === 1'b1) tx_irqs <= tx_irqs + 1;
      if (receive_done_irq === 1'b1) rx_irqs <= rx_irqs + 1;
   end

   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic give_up();
      bad_count++;
      $display("mismatch at %0t: wait ran out", $time);
      report_and_stop();
   endtask : give_up

   // One APB transfer; the idle edge first keeps back-to-back calls from double assignment
   task automatic apb(input logic [15:0] idx, input bit wr, input logic [7:0] wd);
      int i;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= {24'h000000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) give_up();
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic regs_and_pins();
      apb(IDX_ASYNC, 0, 8'h00); chk(rd, ASYNC_RST);
      apb(IDX_SOP, 0, 8'h00); chk(rd, SOP_RST);
      apb(16'h0000, 0, 8'h00); chk(err, 1'b1); chk(rd, 0);
      apb(IDX_SOP, 1, 8'hff); apb(IDX_SOP, 0, 8'h00); chk(rd, 8'hcf);
      repeat (4) @(posedge pclk);
      chk(comm_allowed, 1'b0);
      slave_select_pin <= 1'b0;
      repeat (4) @(posedge pclk);
      chk(comm_allowed, 1'b1);
      chk({sync_serial_clock_pin_oe, sync_serial_clock_pin_o}, 2'b10);
      slave_select_pin <= 1'b1;
      apb(IDX_SOP, 1, 8'h00);
      repeat (4) @(posedge pclk);
      chk(comm_allowed, 1'b1);
      chk({sync_serial_clock_pin_oe, sync_serial_clock_pin_o}, 2'b01);
   endtask : regs_and_pins

   task automatic tx_frames();
      logic [11:0] e;
      logic [1:0]  pm;
      int          k, i, nb, hp, n, c;
      for (k = 0; k < 6; k++) begin
         pm = TXT[k][11:10];
         nb = TXT[k][9] ? 8 : 7;
         hp = (pm != PAR_NONE);
         e = 12'h000;
         for (i = 0; i < nb; i++) e[i] = TXT[k][i];
         if (hp) e[nb] = (pm == PAR_EVEN) ? ^e : (pm == PAR_ODD) ? ~^e : 1'b0;
         e[nb+hp] = 1'b1;
         n = nb + hp + 1;
         frame_bits <= 4'(n);
         apb(IDX_ASYNC, 1, {2'b10, pm, TXT[k][9:8], 2'b00});
         c = tx_irqs;
         apb(IDX_DATA, 1, TXT[k][7:0]);
         for (i = 0; i < 1000 && tx_irqs == c; i++) @(posedge pclk);
         if (tx_irqs == c) give_up();
         chk(got & ((12'h001 << n) - 12'h001), e);
         chk(serial_tx_pin, 1'b1);
         chk(tx_irqs, c + 1);
         apb(IDX_TXFLAG, 0, 8'h00); chk(rd[0], 1'b1);
         apb(IDX_TXFLAG, 1, 8'h01);
      end
      // Cut a frame by clearing transmit enable, then recover the way software must
      c = tx_irqs;
      apb(IDX_DATA, 1, 8'h55);
      repeat (100) @(posedge pclk);
      apb(IDX_ASYNC, 1, 8'h00);
      apb(IDX_DATA, 1, 8'hff);
      apb(IDX_ASYNC, 1, 8'h88);
      repeat (40) @(posedge pclk);
      chk(serial_tx_pin, 1'b1);
      chk(tx_irqs, c);
      apb(IDX_TXFLAG, 0, 8'h00); chk(rd[1:0], 2'b00);
   endtask : tx_frames

   task automatic rx_frames();
      logic [7:0] m;
      logic [1:0] pm;
      logic       p;
      int         k, c;
      for (k = 0; k < 8; k++) begin
         pm = RXT[k][16:15];
         m = RXT[k][14] ? RXT[k][7:0] : {1'b0, RXT[k][6:0]};
         p = ((pm == PAR_EVEN) ? ^m : (pm == PAR_ODD) ? ~^m : 1'b0) ^ RXT[k][13];
         apb(IDX_ASYNC, 1, {2'b01, pm, RXT[k][14], 3'b000});
         c = rx_irqs;
         u_uasy_remote.send(RXT[k][7:0], RXT[k][14] ? 8 : 7, pm != PAR_NONE, p, RXT[k][12]);
         repeat (3) @(posedge pclk);
         chk(rx_irqs, c + 1);
         apb(IDX_ERR, 0, 8'h00); chk(rd, RXT[k][10:8]);
         if (RXT[k][11]) begin
            apb(IDX_DATA, 0, 8'h00); chk(rd, m);
         end
      end
   endtask : rx_frames

   task automatic rx_abort();
      int c;
      apb(IDX_ASYNC, 1, 8'h78);
      c = rx_irqs;
      fork
         u_uasy_remote.send(8'h11, 8, 1'b1, 1'b0, 1'b1);
         begin
            repeat (150) @(posedge pclk);
            apb(IDX_ASYNC, 1, 8'h00);
         end
      join
      repeat (3) @(posedge pclk);
      chk(rx_irqs, c);
      apb(IDX_ERR, 0, 8'h00); chk(rd, 0);
      apb(IDX_DATA, 0, 8'h00); chk(rd, 8'h7f);
   endtask : rx_abort

   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      presetn = 1'b0;
      slave_select_pin = 1'b1;
      frame_bits = 4'h0;
      {bad_count, n_compared} = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      regs_and_pins();
      tx_frames();
      rx_frames();
      rx_abort();
      report_and_stop();
   end
endmodule : tb
